/* File: rtl/bss_boot_source_selector.sv */
// Operation
// - a blank or zero fuse field hands the choice to the strap pins.
// - strap pins are captured once after reset and never again.
// - fuse 1,2,6,7,8,9: serial A, quad, usb A, usb B, spi, serial B.
// - fuse 3,4,5: static memory, chip select zero, 8/16/32 bit bus.
// - straps 0..8: ser A, quad, mem 8/16/32, usb A/B, spi, ser B.
// - spi boot puts sync serial clock, select, in, out on own pins.
// - pin multiplexing follows whichever spi style boot was chosen.
// - after any reset the processor fetches from the 64 kB boot rom.
`timescale 1ns/1ps
module bss_boot_source_selector
    import bss_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        fuse_programmed_i,
    input  wire logic [3:0]  boot_source_fuse_field_i,
    input  wire logic        strap_pin_3_i,
    input  wire logic        strap_pin_2_i,
    input  wire logic        strap_pin_1_i,
    input  wire logic        strap_pin_0_i,
    output logic [3:0]       boot_source_o,
    output logic             boot_valid_o,
    output logic             boot_invalid_o,
    output logic             strap_mode_o,
    output logic [5:0]       smem_width_o,
    output logic             smem_chip_select_zero_o,
    output logic [1:0]       pin_plan_o,
    output logic             sync_serial_clock_fn_o,
    output logic             sync_serial_select_fn_o,
    output logic             sync_serial_in_fn_o,
    output logic             sync_serial_out_fn_o,
    output logic             quad_flash_fn_o,
    output logic             rom_fetch_o,
    output logic [31:0]      rom_fetch_addr_o
);

    // fuse field decode
    function automatic bss_src_t fuse_decode(input logic [3:0] code);
        unique case (code)
            BSS_FUSE_SERIAL_A: fuse_decode = BSS_SRC_SERIAL_A;
            BSS_FUSE_QUAD:     fuse_decode = BSS_SRC_QUAD;
            BSS_FUSE_SMEM8:    fuse_decode = BSS_SRC_SMEM8;
            BSS_FUSE_SMEM16:   fuse_decode = BSS_SRC_SMEM16;
            BSS_FUSE_SMEM32:   fuse_decode = BSS_SRC_SMEM32;
            BSS_FUSE_USB_A:    fuse_decode = BSS_SRC_USB_A;
            BSS_FUSE_USB_B:    fuse_decode = BSS_SRC_USB_B;
            BSS_FUSE_SPI:      fuse_decode = BSS_SRC_SPI;
            BSS_FUSE_SERIAL_B: fuse_decode = BSS_SRC_SERIAL_B;
            default:           fuse_decode = BSS_SRC_INVALID;
        endcase
    endfunction : fuse_decode

    // strap value decode, pin 3 is the msb
    function automatic bss_src_t strap_decode(input logic [3:0] code);
        unique case (code)
            BSS_STRAP_SERIAL_A: strap_decode = BSS_SRC_SERIAL_A;
            BSS_STRAP_QUAD:     strap_decode = BSS_SRC_QUAD;
            BSS_STRAP_SMEM8:    strap_decode = BSS_SRC_SMEM8;
            BSS_STRAP_SMEM16:   strap_decode = BSS_SRC_SMEM16;
            BSS_STRAP_SMEM32:   strap_decode = BSS_SRC_SMEM32;
            BSS_STRAP_USB_A:    strap_decode = BSS_SRC_USB_A;
            BSS_STRAP_USB_B:    strap_decode = BSS_SRC_USB_B;
            BSS_STRAP_SPI:      strap_decode = BSS_SRC_SPI;
            BSS_STRAP_SERIAL_B: strap_decode = BSS_SRC_SERIAL_B;
            default:            strap_decode = BSS_SRC_INVALID;
        endcase
    endfunction : strap_decode

    // pin synchroniser: three stages, change counts when 2 and 3 agree
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] strap_raw;
    logic [3:0] strap_d;
    logic [3:0] strap_q;

    assign strap_raw = {strap_pin_3_i, strap_pin_2_i,
                        strap_pin_1_i, strap_pin_0_i};

    always_comb begin
        strap_d = strap_q;
        if (sync2_q == sync3_q) begin
            strap_d = sync3_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            strap_q <= 4'h0;
        end else begin
            sync1_q <= strap_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            strap_q <= strap_d;
        end
    end

    // capture sequencer and held result
    bss_state_t state_q;
    bss_state_t state_d;
    logic [3:0] settle_q;
    logic [3:0] settle_d;
    bss_src_t   src_q;
    bss_src_t   src_d;
    logic       strap_mode_q;
    logic       strap_mode_d;
    logic       use_straps;

    // an unprogrammed part reads as blank no matter what the field shows
    assign use_straps = !fuse_programmed_i
                        || (boot_source_fuse_field_i
                            == BSS_FUSE_BLANK);

    always_comb begin
        state_d      = state_q;
        settle_d     = settle_q;
        src_d        = src_q;
        strap_mode_d = strap_mode_q;
        unique case (state_q)
            BSS_ST_RESET: begin
                settle_d = 4'h0;
                state_d  = BSS_ST_SAMPLE;
            end
            BSS_ST_SAMPLE: begin
                // wait for the synchroniser to fill with real pin levels
                if (settle_q == BSS_STRAP_SETTLE) begin
                    strap_mode_d = use_straps;
                    if (use_straps) begin
                        src_d = strap_decode(strap_q);
                    end else begin
                        src_d = fuse_decode(boot_source_fuse_field_i);
                    end
                    state_d = BSS_ST_DONE;
                end else begin
                    settle_d = settle_q + 4'h1;
                end
            end
            BSS_ST_DONE: begin
                // held until the next reset; later strap moves ignored
                state_d = BSS_ST_DONE;
            end
            default: begin
                state_d = BSS_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_q      <= BSS_ST_RESET;
            settle_q     <= 4'h0;
            src_q        <= BSS_SRC_INVALID;
            strap_mode_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            settle_q     <= settle_d;
            src_q        <= src_d;
            strap_mode_q <= strap_mode_d;
        end
    end

    // output decode, registered so the loader sees clean levels
    logic        done;
    logic [5:0]  width_d;
    logic [1:0]  plan_d;
    logic [5:0]  width_q;
    logic [1:0]  plan_q;
    logic        valid_q;
    logic        invalid_q;
    logic        fetch_q;

    assign done = (state_q == BSS_ST_DONE);

    always_comb begin
        width_d = BSS_WIDTH_NONE;
        plan_d  = BSS_PINS_NONE;
        if (done) begin
            unique case (src_q)
                BSS_SRC_SMEM8:  width_d = BSS_WIDTH_8;
                BSS_SRC_SMEM16: width_d = BSS_WIDTH_16;
                BSS_SRC_SMEM32: width_d = BSS_WIDTH_32;
                BSS_SRC_QUAD:   plan_d  = BSS_PINS_QUAD;
                BSS_SRC_SPI:    plan_d  = BSS_PINS_SYNC;
                default: begin
                    width_d = BSS_WIDTH_NONE;
                    plan_d  = BSS_PINS_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            width_q   <= BSS_WIDTH_NONE;
            plan_q    <= BSS_PINS_NONE;
            valid_q   <= 1'b0;
            invalid_q <= 1'b0;
            fetch_q   <= 1'b0;
        end else begin
            width_q   <= width_d;
            plan_q    <= plan_d;
            valid_q   <= done && (src_q != BSS_SRC_INVALID);
            invalid_q <= done && (src_q == BSS_SRC_INVALID);
            fetch_q   <= 1'b1;
        end
    end

    assign boot_source_o           = src_q;
    assign boot_valid_o            = valid_q;
    assign boot_invalid_o          = invalid_q;
    assign strap_mode_o            = strap_mode_q;
    assign smem_width_o            = width_q;
    assign smem_chip_select_zero_o = (width_q != BSS_WIDTH_NONE);
    assign pin_plan_o              = plan_q;
    // sync serial functions are a separate pin set from the quad port
    assign sync_serial_clock_fn_o  = (plan_q == BSS_PINS_SYNC);
    assign sync_serial_select_fn_o = (plan_q == BSS_PINS_SYNC);
    assign sync_serial_in_fn_o     = (plan_q == BSS_PINS_SYNC);
    assign sync_serial_out_fn_o    = (plan_q == BSS_PINS_SYNC);
    assign quad_flash_fn_o         = (plan_q == BSS_PINS_QUAD);
    assign rom_fetch_o             = fetch_q;
    assign rom_fetch_addr_o        = BSS_ROM_BASE;

endmodule : bss_boot_source_selector

/* File: rtl/bss_pkg.sv */
package bss_pkg;
    // boot interface codes handed to the loader
    typedef enum logic [3:0] {
        BSS_SRC_SERIAL_A = 4'h0,
        BSS_SRC_QUAD     = 4'h1,
        BSS_SRC_SMEM8    = 4'h2,
        BSS_SRC_SMEM16   = 4'h3,
        BSS_SRC_SMEM32   = 4'h4,
        BSS_SRC_USB_A    = 4'h5,
        BSS_SRC_USB_B    = 4'h6,
        BSS_SRC_SPI      = 4'h7,
        BSS_SRC_SERIAL_B = 4'h8,
        BSS_SRC_INVALID  = 4'hf
    } bss_src_t;

    // pin function plan for the shared flash pins
    typedef enum logic [1:0] {
        BSS_PINS_NONE = 2'h0,
        BSS_PINS_QUAD = 2'h1,
        BSS_PINS_SYNC = 2'h2
    } bss_pins_t;

    // loader sequencing
    typedef enum logic [1:0] {
        BSS_ST_RESET  = 2'h0,
        BSS_ST_SAMPLE = 2'h1,
        BSS_ST_DONE   = 2'h2
    } bss_state_t;

    localparam logic [3:0]  BSS_FUSE_BLANK     = 4'h0;
    localparam logic [3:0]  BSS_FUSE_SERIAL_A  = 4'h1;
    localparam logic [3:0]  BSS_FUSE_QUAD      = 4'h2;
    localparam logic [3:0]  BSS_FUSE_SMEM8     = 4'h3;
    localparam logic [3:0]  BSS_FUSE_SMEM16    = 4'h4;
    localparam logic [3:0]  BSS_FUSE_SMEM32    = 4'h5;
    localparam logic [3:0]  BSS_FUSE_USB_A     = 4'h6;
    localparam logic [3:0]  BSS_FUSE_USB_B     = 4'h7;
    localparam logic [3:0]  BSS_FUSE_SPI       = 4'h8;
    localparam logic [3:0]  BSS_FUSE_SERIAL_B  = 4'h9;

    localparam logic [3:0]  BSS_STRAP_SERIAL_A = 4'h0;
    localparam logic [3:0]  BSS_STRAP_QUAD     = 4'h1;
    localparam logic [3:0]  BSS_STRAP_SMEM8    = 4'h2;
    localparam logic [3:0]  BSS_STRAP_SMEM16   = 4'h3;
    localparam logic [3:0]  BSS_STRAP_SMEM32   = 4'h4;
    localparam logic [3:0]  BSS_STRAP_USB_A    = 4'h5;
    localparam logic [3:0]  BSS_STRAP_USB_B    = 4'h6;
    localparam logic [3:0]  BSS_STRAP_SPI      = 4'h7;
    localparam logic [3:0]  BSS_STRAP_SERIAL_B = 4'h8;

    // static memory data widths in bits
    localparam logic [5:0]  BSS_WIDTH_8        = 6'h08;
    localparam logic [5:0]  BSS_WIDTH_16       = 6'h10;
    localparam logic [5:0]  BSS_WIDTH_32       = 6'h20;
    localparam logic [5:0]  BSS_WIDTH_NONE     = 6'h00;

    // boot rom: 64 kB, first fetch at its base
    localparam int          BSS_ROM_KBYTES     = 64;
    localparam logic [31:0] BSS_ROM_BASE       = 32'h0000_0000;
    localparam logic [31:0] BSS_ROM_SIZE       = 32'h0001_0000;

    // strap settle: cycles counted in the sample state before capture, pin stability not checked
    localparam logic [3:0]  BSS_STRAP_SETTLE   = 4'h4;
endpackage : bss_pkg

/* File: test/bss_boot_source_selector_checker.sv */
`timescale 1ns/1ps
module bss_checker
    import bss_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        fuse_programmed_i,
    input wire logic [3:0]  boot_source_fuse_field_i,
    input wire logic [3:0]  boot_source_o,
    input wire logic        boot_valid_o,
    input wire logic        boot_invalid_o,
    input wire logic        strap_mode_o,
    input wire logic [5:0]  smem_width_o,
    input wire logic        smem_chip_select_zero_o,
    input wire logic [1:0]  pin_plan_o,
    input wire logic        sync_serial_clock_fn_o,
    input wire logic        sync_serial_select_fn_o,
    input wire logic        sync_serial_in_fn_o,
    input wire logic        sync_serial_out_fn_o,
    input wire logic        quad_flash_fn_o,
    input wire logic        rom_fetch_o,
    input wire logic [31:0] rom_fetch_addr_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // decision waits out the settle window, then one flag only
    sequence s_wait; (!boot_valid_o && !boot_invalid_o)[*7]; endsequence
    sequence s_done; boot_valid_o ^ boot_invalid_o; endsequence
    property p_timing; $rose(resetn_i) |-> s_wait ##1 s_done; endproperty
    property p_fetch; $rose(resetn_i) |-> ##2 rom_fetch_o
        && rom_fetch_addr_o == BSS_ROM_BASE; endproperty
    property p_mode; $rose(resetn_i) |-> ##7 strap_mode_o ==
        (!fuse_programmed_i || boot_source_fuse_field_i == BSS_FUSE_BLANK);
    endproperty
    property p_fn; {sync_serial_clock_fn_o, sync_serial_select_fn_o,
        sync_serial_in_fn_o, sync_serial_out_fn_o} ==
        {4{boot_valid_o && boot_source_o == BSS_SRC_SPI}}
        && quad_flash_fn_o ==
        (boot_valid_o && boot_source_o == BSS_SRC_QUAD); endproperty
    property p_plan; boot_valid_o |-> pin_plan_o ==
        (boot_source_o == BSS_SRC_SPI ? BSS_PINS_SYNC :
         boot_source_o == BSS_SRC_QUAD ? BSS_PINS_QUAD : BSS_PINS_NONE);
    endproperty
    property p_mem; boot_valid_o |-> smem_chip_select_zero_o ==
        (boot_source_o inside {BSS_SRC_SMEM8, BSS_SRC_SMEM16, BSS_SRC_SMEM32})
        && smem_width_o == (boot_source_o == BSS_SRC_SMEM8 ? BSS_WIDTH_8 :
        boot_source_o == BSS_SRC_SMEM16 ? BSS_WIDTH_16 :
        boot_source_o == BSS_SRC_SMEM32 ? BSS_WIDTH_32 : BSS_WIDTH_NONE);
    endproperty
    property p_inv; boot_invalid_o |->
        boot_source_o == BSS_SRC_INVALID && !boot_valid_o; endproperty
    // late strap motion must not disturb a taken decision
    property p_hold; boot_valid_o && $past(boot_valid_o) |->
        $stable(boot_source_o) && $stable(pin_plan_o); endproperty
    a_timing: assert property (p_timing) else $error("bad timing");
    a_fetch: assert property (p_fetch) else $error("no rom fetch");
    a_mode: assert property (p_mode) else $error("bad mode");
    a_fn: assert property (p_fn) else $error("bad pin fns");
    a_plan: assert property (p_plan) else $error("bad plan");
    a_mem: assert property (p_mem) else $error("bad memory");
    a_inv: assert property (p_inv) else $error("bad invalid");
    a_hold: assert property (p_hold) else $error("result moved");
endmodule : bss_checker
bind bss_boot_source_selector bss_checker bss_checker_i (
    .ref_clk_i, .resetn_i, .fuse_programmed_i, .boot_source_fuse_field_i,
    .boot_source_o, .boot_valid_o, .boot_invalid_o, .strap_mode_o,
    .smem_width_o, .smem_chip_select_zero_o, .pin_plan_o,
    .sync_serial_clock_fn_o, .sync_serial_select_fn_o, .sync_serial_in_fn_o,
    .sync_serial_out_fn_o, .quad_flash_fn_o, .rom_fetch_o, .rom_fetch_addr_o
);

/* File: test/bss_strap_board.sv */
`timescale 1ns/1ps
module bss_strap_board (
    input  wire logic       fitted_i,
    input  wire logic [3:0] value_i,
    output logic      [3:0] pins_o
);
    // removed jumpers leave the pull-ups in charge
    assign pins_o = fitted_i ? value_i : 4'hf;
endmodule : bss_strap_board

/* File: test/tb_boot_source_selector.sv */
`timescale 1ns/1ps
module tb_boot_source_selector
    import bss_pkg::*;
;
    logic        ref_clk_i, resetn_i, fuse_programmed_i, fit;
    logic [3:0]  boot_source_fuse_field_i, sval, pins, boot_source_o;
    logic        boot_valid_o, boot_invalid_o, strap_mode_o, rom_fetch_o;
    logic        smem_chip_select_zero_o, quad_flash_fn_o;
    logic        sync_serial_clock_fn_o, sync_serial_select_fn_o;
    logic        sync_serial_in_fn_o, sync_serial_out_fn_o;
    logic [5:0]  smem_width_o;
    logic [1:0]  pin_plan_o;
    logic [31:0] rom_fetch_addr_o;
    int          fails = 0;
    int          n_compared = 0;
    bss_strap_board bss_strap_board_i (.fitted_i(fit), .value_i(sval),
        .pins_o(pins));
    bss_boot_source_selector bss_boot_source_selector_i (
        .ref_clk_i, .resetn_i, .fuse_programmed_i, .boot_source_fuse_field_i,
        .strap_pin_3_i(pins[3]), .strap_pin_2_i(pins[2]),
        .strap_pin_1_i(pins[1]), .strap_pin_0_i(pins[0]),
        .boot_source_o, .boot_valid_o, .boot_invalid_o, .strap_mode_o,
        .smem_width_o, .smem_chip_select_zero_o, .pin_plan_o,
        .sync_serial_clock_fn_o, .sync_serial_select_fn_o,
        .sync_serial_in_fn_o, .sync_serial_out_fn_o, .quad_flash_fn_o,
        .rom_fetch_o, .rom_fetch_addr_o);
    // 20 mhz reference
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    // fuse codes sit one above the strap codes of the same source
    function automatic logic [3:0] exp_src(input logic s, input logic [3:0] c);
        if (s) return (c <= 4'h8) ? c : 4'hf;
        return (c <= 4'h9) ? c - 4'h1 : 4'hf;
    endfunction : exp_src
    // one full reset and decision, straps held throughout
    task automatic boot(input logic p, input logic [3:0] f,
                        input logic [3:0] s);
        logic [3:0] e;
        logic       sm;
        int         n;
        @(posedge ref_clk_i);
        #5;
        resetn_i = 1'b0;
        fuse_programmed_i = p;
        boot_source_fuse_field_i = f;
        sval = s;
        fit = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #5;
        cmp("rst_source", 4'hf, boot_source_o);
        cmp("rst_fetch", 0, rom_fetch_o);
        resetn_i = 1'b1;
        sm = !p || f == 4'h0;
        e = exp_src(sm, sm ? s : f);
        for (n = 0; n < 20 && boot_valid_o !== 1'b1
             && boot_invalid_o !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #5;
        end
        if (n == 20) begin
            fails++;
            final_report();
        end
        cmp("latency", 7, n);
        cmp("valid", e != 4'hf, boot_valid_o);
        cmp("strap_mode", sm, strap_mode_o);
        cmp("source", e, boot_source_o);
        cmp("invalid", e == 4'hf, boot_invalid_o);
        cmp("width", e == 4'h2 ? 8 : e == 4'h3 ? 16 : e == 4'h4 ? 32 : 0,
            smem_width_o);
        cmp("cs0", e inside {[4'h2:4'h4]}, smem_chip_select_zero_o);
        cmp("plan", e == 4'h7 ? 2 : e == 4'h1 ? 1 : 0, pin_plan_o);
        cmp("sync_fn", {4{e == 4'h7}}, {sync_serial_clock_fn_o,
            sync_serial_select_fn_o, sync_serial_in_fn_o,
            sync_serial_out_fn_o});
        cmp("quad_fn", e == 4'h1, quad_flash_fn_o);
        cmp("fetch", 1, rom_fetch_o);
        cmp("addr", BSS_ROM_BASE, rom_fetch_addr_o);
    endtask : boot
    // programmed zero falls back to the straps
    task automatic t_blank;
        boot(1'b1, 4'h0, 4'h7);
    endtask : t_blank
    // every fuse code from 1 to 15, straps at 8 (serial B)
    task automatic t_fuse;
        for (int c = 1; c < 16; c++) boot(1'b1, c[3:0], 4'h8);
    endtask : t_fuse
    // every strap value with fuses not programmed
    task automatic t_strap;
        for (int v = 0; v < 16; v++) boot(1'b0, 4'h6, v[3:0]);
    endtask : t_strap
    // straps moved, then jumpers pulled, after the decision
    task automatic t_late;
        boot(1'b0, 4'h0, 4'h1);
        sval = 4'h7;
        repeat (10) @(posedge ref_clk_i);
        #5;
        fit = 1'b0;
        repeat (10) @(posedge ref_clk_i);
        #5;
        cmp("late_source", 4'h1, boot_source_o);
        cmp("late_plan", 1, pin_plan_o);
    endtask : t_late
    // main sequence
    initial begin
        resetn_i = 1'b0;
        fuse_programmed_i = 1'b0;
        boot_source_fuse_field_i = 4'h0;
        sval = 4'h0;
        fit = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        t_blank();
        t_fuse();
        t_strap();
        t_late();
        final_report();
    end
endmodule : tb_boot_source_selector
